/* dfm_top.sv */
/*
 * drive fault monitor: speed and feedback supervision, alarm flags,
 * fault log and nonvolatile write gating behind an axi4-lite slave.
 * assumes pulse_cmd_in and fault_reset_input are asynchronous pins;
 * all other inputs come from logic on aclk.
 */
`timescale 1ns/1ps
module dfm_top #(
  parameter int WIN_C  = dfm_pkg::WIN_CYC,
  parameter int WDOG_C = dfm_pkg::WDOG_CYC
) (
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic [7:0]  s_awaddr,
  input  wire  logic        s_awvalid,
  output logic              s_awready,
  input  wire  logic [31:0] s_wdata,
  input  wire  logic [3:0]  s_wstrb,
  input  wire  logic        s_wvalid,
  output logic              s_wready,
  output logic [1:0]        s_bresp,
  output logic              s_bvalid,
  input  wire  logic        s_bready,
  input  wire  logic [7:0]  s_araddr,
  input  wire  logic        s_arvalid,
  output logic              s_arready,
  output logic [31:0]       s_rdata,
  output logic [1:0]        s_rresp,
  output logic              s_rvalid,
  input  wire  logic        s_rready,
  input  wire  logic        pulse_cmd_in,
  input  wire  logic        fault_reset_input,
  input  wire  logic        fb_out_pulse,
  input  wire  logic        cpu_heartbeat,
  input  wire  logic        ram_check_err,
  input  wire  logic        nvm_done,
  input  wire  logic        nvm_err,
  output logic              nvm_wr_start,
  output logic              nvm_commit,
  output logic              factory_init,
  output dfm_pkg::dfm_alarm_t alarms,
  output logic [2:0]        warn_cause
);
  import dfm_pkg::*;

  localparam int RATE = CLK_HZ / WIN_C;

  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d, rmux;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        inh_q, inh_d;
  logic [15:0] cr_q, cr_d, fr_q, fr_d, vl_q, vl_d;
  logic [2:0]  sel_q, sel_d, lwp_q, lwp_d;
  logic [3:0]  lcnt_q, lcnt_d;
  logic [1:0]  log_q [LOG_DEPTH];
  logic [1:0]  log_d [LOG_DEPTH];
  dfm_alarm_t  alm_q, alm_d;
  logic [2:0]  cause_q, cause_d, hit_q, hit_d, new_hit;
  logic [15:0] wcnt_q, wcnt_d, pcnt_q, pcnt_d, fcnt_q, fcnt_d;
  logic [15:0] pcnt_n, fcnt_n;
  logic [3:0]  ocnt_q, ocnt_d;
  logic [15:0] dog_q, dog_d;
  logic        hb_q, hb_d;
  dfm_nv_t     nv_q, nv_d;
  logic        pend_q, pend_d, cpend_q, cpend_d;
  logic        start_q, start_d, cmt_q, cmt_d, fact_q, fact_d;
  logic        ps1_q, ps2_q, ps3_q, rs1_q, rs2_q;
  logic        wr_go, win_end, clr_any, cmd_clr, over;
  logic [47:0] spd, lim0, lim1, fbf;

  // pins pass two flip-flops; the pulse pin adds a third, and its edge is taken from the second and third stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps1_q <= 1'b0;
      ps2_q <= 1'b0;
      ps3_q <= 1'b0;
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      ps1_q <= pulse_cmd_in;
      ps2_q <= ps1_q;
      ps3_q <= ps2_q;
      rs1_q <= fault_reset_input;
      rs2_q <= rs1_q;
    end
  end

  // read mux; log and settings stay readable in any alarm state
  always_comb begin
    rmux = 32'h0;
    unique case (s_araddr)
      A_CTRL:   rmux = {31'h0, inh_q};
      A_STAT:   rmux = {21'h0, cause_q, 2'h0, inh_q,
                        nv_q == NV_BUSY, alm_q};
      A_CIRC:   rmux = {16'h0, cr_q};
      A_FBRES:  rmux = {16'h0, fr_q};
      A_CEIL:   rmux = {16'h0, vl_q};
      A_LOGSEL: rmux = {29'h0, sel_q};
      A_LOGDAT: rmux = {12'h0, lcnt_q, 5'h0, lwp_q, 6'h0, log_q[sel_q]};
      default:  rmux = 32'h0;
    endcase
  end

  // window arithmetic: speed in rev/s scaled by circle resolution
  always_comb begin
    pcnt_n = pcnt_q + {15'h0, ps2_q & ~ps3_q};
    fcnt_n = fcnt_q + {15'h0, fb_out_pulse};
    spd    = 48'(pcnt_n) * 48'(RATE);
    lim0   = 48'(SPD_MAX_RPS) * 48'(cr_q);
    lim1   = 48'(CEIL_NUM) * 48'(vl_q) * 48'(cr_q);
    fbf    = 48'(fcnt_n) * 48'(RATE);
    over   = (spd * 48'(CEIL_DEN)) > lim1;
  end

  // next state of bus, settings, supervision and nonvolatile control
  always_comb begin
    aw_d = aw_q; awa_d = awa_q; w_d = w_q; wd_d = wd_q; ws_d = ws_q;
    bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
    inh_d = inh_q; cr_d = cr_q; fr_d = fr_q; vl_d = vl_q; sel_d = sel_q;
    lwp_d = lwp_q; lcnt_d = lcnt_q; log_d = log_q;
    alm_d = alm_q; cause_d = cause_q; hit_d = hit_q;
    wcnt_d = wcnt_q + 16'h1; pcnt_d = pcnt_n; fcnt_d = fcnt_n;
    ocnt_d = ocnt_q; hb_d = cpu_heartbeat;
    dog_d = (cpu_heartbeat != hb_q) ? 16'h0 : dog_q;
    nv_d = nv_q; pend_d = pend_q; cpend_d = cpend_q;
    start_d = 1'b0; cmt_d = cmt_q; fact_d = 1'b0;
    cmd_clr = 1'b0;
    if (s_awvalid && s_awready) begin
      aw_d = 1'b1;
      awa_d = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_d = 1'b1;
      wd_d = s_wdata;
      ws_d = s_wstrb;
    end
    wr_go = aw_q && w_q;
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = RESP_OK;
      unique case (awa_q)
        A_CTRL: if (ws_q[0]) begin
          inh_d = wd_q[CTRL_INH];
          cmd_clr = wd_q[CTRL_CLR];
          if (wd_q[CTRL_COMMIT] && !alm_q.ram)
            cpend_d = 1'b1;
          if (wd_q[CTRL_FACT] && alm_q.rom) begin
            cr_d = CIRC_RST;
            fr_d = FBRES_RST;
            vl_d = CEIL_RST;
            inh_d = 1'b0;
            fact_d = 1'b1;
          end
        end
        A_CIRC: begin
          cr_d = dfm_merge16(cr_q, wd_q, ws_q);
          pend_d = 1'b1;
        end
        A_FBRES: begin
          fr_d = dfm_merge16(fr_q, wd_q, ws_q);
          vl_d = dfm_ceil_of(fr_d);
          pend_d = 1'b1;
        end
        A_CEIL: begin
          vl_d = dfm_merge16(vl_q, wd_q, ws_q);
          pend_d = 1'b1;
        end
        A_LOGSEL: if (ws_q[0]) sel_d = wd_q[2:0];
        A_STAT, A_LOGDAT: br_d = RESP_OK;
        default: br_d = RESP_ERR;
      endcase
    end
    if (bv_q && s_bready) bv_d = 1'b0;
    if (s_arvalid && s_arready) begin
      rv_d = 1'b1;
      rd_d = rmux;
      rr_d = (s_araddr <= A_LOGDAT && s_araddr[1:0] == 2'h0)
             ? RESP_OK : RESP_ERR;
    end else if (rv_q && s_rready) begin
      rv_d = 1'b0;
    end
    // window end: judge speed and feedback rate, restart counts
    win_end = (wcnt_q >= 16'(WIN_C - 1));
    if (win_end) begin
      wcnt_d = 16'h0;
      pcnt_d = 16'h0;
      fcnt_d = 16'h0;
      ocnt_d = !over ? 4'h0 : (ocnt_q == 4'hf) ? ocnt_q : ocnt_q + 4'h1;
      hit_d[0] = spd > lim0;
      hit_d[1] = over && (ocnt_q >= 4'(OVER_WIN));
      hit_d[2] = fbf > 48'(FB_MAX_HZ);
    end
    new_hit = hit_d & ~hit_q;
    clr_any = rs2_q || cmd_clr;
    if (clr_any) begin
      alm_d.warn = 1'b0;
      cause_d = 3'h0;
    end
    if (new_hit != 3'h0) begin
      alm_d.warn = 1'b1; // set wins over clear
      cause_d = cause_d | new_hit;
      log_d[lwp_q] = new_hit[0] ? 2'h0 : new_hit[1] ? 2'h1 : 2'h2;
      lwp_d = lwp_q + 3'h1;
      if (lcnt_q != 4'(LOG_DEPTH)) lcnt_d = lcnt_q + 4'h1;
    end
    // cpu, ram and rom alarms only fall at reset (power cycle); warn also falls on a clear
    if (dog_q >= 16'(WDOG_C - 1)) alm_d.cpu = 1'b1;
    else dog_d = (cpu_heartbeat != hb_q) ? 16'h0 : dog_q + 16'h1;
    if (ram_check_err) alm_d.ram = 1'b1;
    unique case (nv_q)
      NV_IDLE: begin
        if (cpend_q && !alm_q.ram) begin
          start_d = 1'b1;
          cmt_d = 1'b1;
          cpend_d = 1'b0;
          pend_d = 1'b0;
          nv_d = NV_BUSY;
        end else if (pend_q && !inh_q && !alm_q.ram) begin
          start_d = 1'b1;
          cmt_d = 1'b0;
          pend_d = 1'b0;
          nv_d = NV_BUSY;
        end
      end
      NV_BUSY: begin
        if (nvm_done || nvm_err) begin
          nv_d = NV_IDLE;
          cmt_d = 1'b0;
        end
        if (nvm_err) alm_d.rom = 1'b1;
      end
      default: nv_d = NV_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; awa_q <= 8'h0; w_q <= 1'b0; wd_q <= 32'h0;
      ws_q <= 4'h0; bv_q <= 1'b0; br_q <= RESP_OK; rv_q <= 1'b0;
      rd_q <= 32'h0; rr_q <= RESP_OK; inh_q <= 1'b0;
      cr_q <= CIRC_RST; fr_q <= FBRES_RST; vl_q <= CEIL_RST;
      sel_q <= 3'h0; lwp_q <= 3'h0; lcnt_q <= 4'h0;
      for (int i = 0; i < LOG_DEPTH; i++) log_q[i] <= 2'h0;
      alm_q <= '0; cause_q <= 3'h0; hit_q <= 3'h0;
      wcnt_q <= 16'h0; pcnt_q <= 16'h0; fcnt_q <= 16'h0;
      ocnt_q <= 4'h0; dog_q <= 16'h0; hb_q <= 1'b0;
      nv_q <= NV_IDLE; pend_q <= 1'b0; cpend_q <= 1'b0;
      start_q <= 1'b0; cmt_q <= 1'b0; fact_q <= 1'b0;
    end else begin
      aw_q <= aw_d; awa_q <= awa_d; w_q <= w_d; wd_q <= wd_d;
      ws_q <= ws_d; bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d;
      rd_q <= rd_d; rr_q <= rr_d; inh_q <= inh_d;
      cr_q <= cr_d; fr_q <= fr_d; vl_q <= vl_d;
      sel_q <= sel_d; lwp_q <= lwp_d; lcnt_q <= lcnt_d;
      log_q <= log_d;
      alm_q <= alm_d; cause_q <= cause_d; hit_q <= hit_d;
      wcnt_q <= wcnt_d; pcnt_q <= pcnt_d; fcnt_q <= fcnt_d;
      ocnt_q <= ocnt_d; dog_q <= dog_d; hb_q <= hb_d;
      nv_q <= nv_d; pend_q <= pend_d; cpend_q <= cpend_d;
      start_q <= start_d; cmt_q <= cmt_d; fact_q <= fact_d;
    end
  end

  // handshakes are combinational, data straight from flip-flops
  assign s_awready    = !aw_q && !bv_q;
  assign s_wready     = !w_q && !bv_q;
  assign s_bvalid     = bv_q;
  assign s_bresp      = br_q;
  assign s_arready    = !rv_q;
  assign s_rvalid     = rv_q;
  assign s_rdata      = rd_q;
  assign s_rresp      = rr_q;
  assign nvm_wr_start = start_q;
  assign nvm_commit   = cmt_q;
  assign factory_init = fact_q;
  assign alarms       = alm_q;
  assign warn_cause   = cause_q;

  // checks
  speed_warn_a: assert property (@(posedge aclk) disable iff (!aresetn)
    win_end && spd > lim0 && !hit_q[0] |=> alm_q.warn && cause_q[0])
    else $error("speed warning not raised");
  ceil_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    win_end && over && ocnt_q >= 4'(OVER_WIN) && !hit_q[1] |=> cause_q[1])
    else $error("ceiling warning not raised");
  fb_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    win_end && fbf > 48'(FB_MAX_HZ) && !hit_q[2] |=> cause_q[2])
    else $error("feedback rate warning not raised");
  log_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    new_hit[1:0] == 2'h2 |=> log_q[$past(lwp_q)] == 2'h1)
    else $error("log entry wrong");
  ceil_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && awa_q == A_FBRES |=> vl_q == dfm_ceil_of(fr_q))
    else $error("ceiling not reloaded");
  warn_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clr_any && new_hit == 3'h0 |=> !alm_q.warn && cause_q == 3'h0)
    else $error("warning not cleared");
  warn_stick_a: assert property
    (@(posedge aclk) disable iff (!aresetn)
    $fell(alm_q.warn) |-> $past(clr_any))
    else $error("warning dropped without clear");
  cpu_dog_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dog_q >= 16'(WDOG_C - 1) |=> alm_q.cpu [*2])
    else $error("processor alarm missing");
  ram_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    alm_q.ram |=> !start_q)
    else $error("nvm write during ram fault");
  read_ans_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_arvalid && s_arready |=> s_rvalid)
    else $error("read not answered");
  rom_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    nv_q == NV_BUSY && nvm_err |=> alm_q.rom ##1 alm_q.rom)
    else $error("nvm fault not raised");
  inh_auto_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_q && !cmt_q |-> !$past(inh_q))
    else $error("automatic write while inhibited");
endmodule

/* dfm_pkg.sv */
/*
 * constants, types and helpers for the drive fault monitor.
 * assumes a 50 MHz aclk and an axi4-lite master with 32-bit data.
 */
// Operation
// - warn with cause 0 when pulse-train speed command passes 30 rev/s
// - warn with cause 1 when speed stays above 1.5 x ceiling over 1 ms
// - warn with cause 2 when feedback output frequency passes 2.3 MHz
// - every warning enters a fault log with its lowest-numbered new cause, readable by query
// - speed command formed from input pulse rate over circle resolution
// - writing feedback resolution reloads the speed ceiling automatically
// - fault reset input or fault reset command clears the warning
// - processor fault alarm when the processor stops running properly
// - volatile memory fault alarm when working memory is found corrupt
// - no settings written to nonvolatile memory during volatile fault
// - register and log reads still answered during volatile fault
// - nonvolatile fault alarm when a backup write does not complete well
// - write-inhibit setting suppresses automatic nonvolatile writes
// - commit command stores settings; power must stay until write ends
// - factory defaults during nonvolatile fault reinitialise all settings
package dfm_pkg;
  localparam int CLK_HZ      = 50_000_000;
  localparam int CLK_NS      = 20;
  localparam int WIN_NS      = 100_000;
  localparam int WIN_CYC     = WIN_NS / CLK_NS;
  localparam int OVER_NS     = 1_000_000;
  localparam int OVER_WIN    = OVER_NS / WIN_NS;
  localparam int WDOG_NS     = 1_000_000;
  localparam int WDOG_CYC    = WDOG_NS / CLK_NS;
  localparam int SPD_MAX_RPS = 30;
  localparam int CEIL_NUM    = 3;
  localparam int CEIL_DEN    = 2;
  localparam int FB_MAX_HZ   = 2_300_000;

  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STAT   = 8'h04;
  localparam logic [7:0] A_CIRC   = 8'h08;
  localparam logic [7:0] A_FBRES  = 8'h0c;
  localparam logic [7:0] A_CEIL   = 8'h10;
  localparam logic [7:0] A_LOGSEL = 8'h14;
  localparam logic [7:0] A_LOGDAT = 8'h18;

  localparam int CTRL_INH    = 0;
  localparam int CTRL_COMMIT = 1;
  localparam int CTRL_FACT   = 2;
  localparam int CTRL_CLR    = 3;

  localparam logic [15:0] CIRC_RST  = 16'h1000;
  localparam logic [15:0] FBRES_RST = 16'h1000;
  localparam logic [15:0] CEIL_RST  = 16'h0230;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
  localparam int LOG_DEPTH = 8;

  typedef struct packed {
    logic rom;
    logic ram;
    logic cpu;
    logic warn;
  } dfm_alarm_t;

  typedef enum logic [1:0] {
    NV_IDLE = 2'h1,
    NV_BUSY = 2'h2
  } dfm_nv_t;

  // byte-lane merge of a 16-bit field
  function automatic logic [15:0] dfm_merge16(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
    dfm_merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ceiling that keeps the feedback output under its frequency limit
  function automatic logic [15:0] dfm_ceil_of(input logic [15:0] fr);
    logic [23:0] q;
    q = 24'(FB_MAX_HZ) / ((fr == 16'h0) ? 24'h1 : 24'(fr));
    dfm_ceil_of = (q > 24'h00ffff) ? 16'hffff : q[15:0];
  endfunction
endpackage

/* dfm_far_model.sv */
/*
 * far-side model: pulse-train source, feedback pulses, processor
 * heartbeat and nvm writer. assumes the bench steers it on aclk.
 */
`timescale 1ns/1ps
module dfm_far_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] per,
  input  wire logic       fb_on,
  input  wire logic       hb_on,
  input  wire logic       fail,
  input  wire logic       nvm_wr_start,
  output logic            pulse_cmd_in,
  output logic            fb_out_pulse,
  output logic            cpu_heartbeat,
  output logic            nvm_done,
  output logic            nvm_err
);
  logic [7:0] pc;
  logic [3:0] nc;

  // command pulses stay high two cycles so the pin synchroniser never misses one; feedback pulses last one cycle
  always @(posedge aclk) begin
    if (!aresetn || per == 8'h0 || pc >= per - 8'h1)
      pc <= 8'h0;
    else
      pc <= pc + 8'h1;
    pulse_cmd_in <= aresetn && per != 8'h0 && pc < 8'h2;
    fb_out_pulse <= aresetn && fb_on && !fb_out_pulse;
    cpu_heartbeat <= aresetn && (hb_on ^ cpu_heartbeat);
  end

  // writer answers after a few cycles; the real ~30 s is shortened
  always @(posedge aclk) begin
    if (!aresetn)
      nc <= 4'h0;
    else if (nvm_wr_start)
      nc <= 4'h6;
    else if (nc != 4'h0)
      nc <= nc - 4'h1;
    // gated by reset so no unknown answer leaves the model
    nvm_done <= aresetn && nc == 4'h1 && !fail;
    nvm_err <= aresetn && nc == 4'h1 && fail;
  end
endmodule

/* drive_fault_monitor_tb_top.sv */
/*
 * self-checking bench for the drive fault monitor over axi4-lite.
 * assumes dfm_pkg, dfm_top and dfm_far_model; short windows via params.
 */
`timescale 1ns/1ps
module drive_fault_monitor_tb_top;
  import dfm_pkg::*;
  logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid;
  logic        s_rready, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [7:0]  s_awaddr, s_araddr, per;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic        pulse_cmd_in, fault_reset_input, fb_out_pulse, cpu_heartbeat;
  logic        ram_check_err, nvm_done, nvm_err, nvm_wr_start, nvm_commit;
  logic        factory_init, fb_on, hb_on, fail, last_commit;
  dfm_alarm_t  alarms;
  logic [2:0]  warn_cause;
  int          failures = 0, tests_run = 0, wr_cnt = 0, fi_cnt = 0, seed, k;

  dfm_top #(.WIN_C(50), .WDOG_C(20)) dfm_top_i (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .pulse_cmd_in(pulse_cmd_in),
    .fault_reset_input(fault_reset_input), .fb_out_pulse(fb_out_pulse),
    .cpu_heartbeat(cpu_heartbeat), .ram_check_err(ram_check_err),
    .nvm_done(nvm_done), .nvm_err(nvm_err), .nvm_wr_start(nvm_wr_start),
    .nvm_commit(nvm_commit), .factory_init(factory_init),
    .alarms(alarms), .warn_cause(warn_cause));

  dfm_far_model dfm_far_model_i (
    .aclk(aclk), .aresetn(aresetn), .per(per), .fb_on(fb_on),
    .hb_on(hb_on), .fail(fail), .nvm_wr_start(nvm_wr_start),
    .pulse_cmd_in(pulse_cmd_in), .fb_out_pulse(fb_out_pulse),
    .cpu_heartbeat(cpu_heartbeat), .nvm_done(nvm_done), .nvm_err(nvm_err));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // tally nvm write starts and factory pulses
  always @(posedge aclk) begin
    if (nvm_wr_start) begin
      wr_cnt <= wr_cnt + 1;
      last_commit <= nvm_commit;
    end
    if (factory_init)
      fi_cnt <= fi_cnt + 1;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // every handshake wait is bounded; a stuck slave ends the run
  task automatic tmo(input int n);
    if (n > 100) begin
      failures++;
      end_sim();
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit aw, w;
    int n;
    aw = 0;
    w = 0;
    n = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      aw = aw || s_awready;
      w = w || s_wready;
      if (aw) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
      tmo(++n);
    end
    do begin
      @(posedge aclk);
      tmo(++n);
    end while (!s_bvalid);
    chk("bresp", s_bresp, er);
  endtask

  task automatic rdw(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      tmo(++n);
    end while (!s_arready);
    s_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      tmo(++n);
    end while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rdw(a, d, r);
    chk("rresp", r, RESP_OK);
    chk("rdata", d, exp);
  endtask

  initial begin
    seed = 36;
    {aresetn, s_awvalid, s_wvalid, s_arvalid, fb_on, fail} = 6'h0;
    {s_awaddr, s_araddr, per, s_wdata} = 56'h0;
    {fault_reset_input, ram_check_err} = 2'h0;
    {s_bready, s_rready, hb_on} = 3'h7;
    s_wstrb = 4'hf;
    cyc(3);
    aresetn <= 1'b1;
    rc(A_CIRC, 32'(CIRC_RST));
    rc(A_CEIL, 32'(CEIL_RST));
    wr(A_FBRES, 32'h3e8, RESP_OK);
    rc(A_CEIL, 32'(FB_MAX_HZ / 1000));
    repeat (4) begin
      k = $random(seed);
      wr(A_CIRC, 32'(k), RESP_OK);
      rc(A_CIRC, 32'(k) & 32'hffff);
    end
    wr(8'h1c, 32'h0, RESP_ERR);
    rdw(8'h1c, rd, rsp);
    chk("unmapped rresp", 32'(rsp), 32'(RESP_ERR));
    chk("unmapped rdata", rd, 32'h0);
    // two pulses a window beat 30 rev/s at the largest resolution
    wr(A_CIRC, 32'hffff, RESP_OK);
    wr(A_CEIL, 32'hffff, RESP_OK);
    per <= 8'h14;
    cyc(150);
    per <= 8'h0;
    cyc(60);
    chk("cause0", warn_cause, 3'h1);
    wr(A_CTRL, 32'h8, RESP_OK);
    cyc(2);
    chk("cmd clear", alarms.warn, 1'h0);
    // one pulse a window only beats 1.5 x ceiling, which must last
    wr(A_CEIL, 32'h1, RESP_OK);
    per <= 8'h32;
    cyc(400);
    chk("cause1 early", warn_cause, 3'h0);
    cyc(400);
    per <= 8'h0;
    cyc(60);
    chk("cause1", warn_cause, 3'h2);
    fault_reset_input <= 1'b1;
    cyc(4);
    fault_reset_input <= 1'b0;
    cyc(2);
    chk("pin clear", warn_cause, 3'h0);
    fb_on <= 1'b1;
    cyc(150);
    fb_on <= 1'b0;
    cyc(200);
    chk("cause2", warn_cause, 3'h4);
    rc(A_STAT, 32'h401);
    for (k = 0; k < 3; k++) begin
      wr(A_LOGSEL, 32'(k), RESP_OK);
      rdw(A_LOGDAT, rd, rsp);
      chk("log entry", {rd[19:16], rd[1:0]}, {4'h3, 2'(k)});
    end
    wr(A_CTRL, 32'h1, RESP_OK);
    k = wr_cnt;
    wr(A_CIRC, 32'h1234, RESP_OK);
    cyc(30);
    chk("inhibit", wr_cnt, k);
    rc(A_CTRL, 32'h1);
    wr(A_CTRL, 32'h3, RESP_OK);
    cyc(20);
    chk("commit count", wr_cnt, k + 1);
    chk("commit flag", 32'(last_commit), 32'h1);
    fail <= 1'b1;
    wr(A_CTRL, 32'h2, RESP_OK);
    cyc(20);
    chk("rom", alarms.rom, 1'h1);
    wr(A_CTRL, 32'h4, RESP_OK);
    cyc(3);
    chk("factory", fi_cnt, 32'h1);
    rc(A_CIRC, 32'(CIRC_RST));
    rc(A_FBRES, 32'(FBRES_RST));
    rc(A_CEIL, 32'(CEIL_RST));
    hb_on <= 1'b0;
    cyc(10);
    chk("cpu early", alarms.cpu, 1'h0);
    cyc(20);
    chk("cpu", alarms.cpu, 1'h1);
    hb_on <= 1'b1;
    fail <= 1'b0;
    ram_check_err <= 1'b1;
    cyc(1);
    ram_check_err <= 1'b0;
    cyc(30);
    chk("ram", alarms.ram, 1'h1);
    k = wr_cnt;
    wr(A_CIRC, 32'h55aa, RESP_OK);
    wr(A_CTRL, 32'h2, RESP_OK);
    cyc(30);
    chk("ram gate", wr_cnt, k);
    rc(A_CIRC, 32'h55aa);
    end_sim();
  end
endmodule
